// >>> nv_record_map.vh
// Constants for the register record store and load engine
`ifndef NV_RECORD_MAP_VH
`define NV_RECORD_MAP_VH
`define OP_STORE_SINGLE 3'h0
`define OP_STORE_MULTI 3'h1
`define OP_LOAD_SINGLE 3'h2
`define OP_LOAD_MULTI 3'h3
`define OP_WRITE_PROP 3'h4
`define PROP_START 3'h0
`define PROP_COLS 3'h1
`define PROP_ROWS 3'h2
`define PROP_END 3'h3
`define PROP_INC 3'h4
`define MAX_REGS 4'hA
`define NUM_REGS 5'h10
`define GUARD_WORD 16'h0000
`define HDR_LEN_LSB 0
`define HDR_SUM_LSB 8
`define REC_OVERHEAD 16'h0002
`define CSUM_RESET 8'h00
`define ACC_RESET 32'h00000000
`define FIFO_WIDTH 16
`define FIFO_DEPTH 4
`define FIFO_AW 2
`endif

// >>> word_fifo.v
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module word_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_r;
  reg [AW-1:0] rd_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;

  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem[rd_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk) begin
    if (ce && push) begin
      mem[wr_r] <= in_data;
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_r <= {AW{1'b0}};
      rd_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// >>> nv_record_engine.v
// Register record store and load engine facing non-volatile memory
// Operation
// - Record holds one to ten consecutive registers
// - Store writes header at record start
// - Header: length low byte, checksum high
// - Load checks header length, verifies checksum
// - Second record word is zero guard
// - Registers in order, two words each
// - Load count must match stored count
// - Uninitialized memory reports length error
// - Store single and store multiple operations
// - Load single and load multiple operations
// - Indirect flag uses accumulator as address
// - Length equals data words plus one
// - Each register stored as 32 bits
`timescale 1ns/100ps
`include "nv_record_map.vh"
module nv_record_engine (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire cmd_valid,
  output wire cmd_ready,
  input wire [2:0] cmd_op,
  input wire cmd_indirect,
  input wire [15:0] cmd_addr,
  input wire [3:0] cmd_reg,
  input wire [3:0] cmd_count,
  input wire [2:0] cmd_prop,
  input wire [3:0] arr_cols,
  input wire [15:0] arr_rows,
  input wire reg_wr_en,
  input wire [3:0] reg_wr_idx,
  input wire [31:0] reg_wr_data,
  input wire [3:0] reg_rd_idx,
  output reg [31:0] reg_rd_data,
  output reg [31:0] acc_r,
  output wire busy,
  output reg done_r,
  output reg err_len_r,
  output reg err_sum_r,
  output reg err_cmd_r,
  output wire mem_req,
  output wire mem_we,
  output reg [15:0] mem_addr_r,
  output wire [15:0] mem_wdata,
  input wire mem_ack,
  input wire [15:0] mem_rdata
);
  localparam ST_IDLE = 3'h0;
  localparam ST_SFILL = 3'h1;
  localparam ST_SHDR = 3'h2;
  localparam ST_LHDR = 3'h3;
  localparam ST_LDATA = 3'h4;
  localparam ST_COMMIT = 3'h5;

  reg [31:0] regs [0:15];
  reg [15:0] stage [0:20];
  reg [2:0] state_r;
  reg [15:0] start_r;
  reg [3:0] base_r;
  reg [4:0] wlen_r;
  reg [4:0] push_r;
  reg [4:0] pop_r;
  reg [7:0] csum_r;
  reg [7:0] hsum_r;
  reg [15:0] push_word;
  reg [3:0] cnt_nxt;
  reg [15:0] start_nxt;
  reg [31:0] prop_nxt;
  reg [4:0] pw;
  reg [3:0] pidx;
  wire fifo_in_valid;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire fifo_out_ready;
  wire [15:0] fifo_out_data;
  wire is_store;
  wire is_load;
  wire bad_count;
  wire commit_ok;
  wire [4:0] reg_span;
  integer i;

  // Byte-sum checksum used by both store and load paths
  function [7:0] csum_add;
    input [7:0] sum;
    input [15:0] word;
    begin
      csum_add = sum + word[7:0] + word[15:8];
    end
  endfunction

  assign is_store = (cmd_op == `OP_STORE_SINGLE) || (cmd_op == `OP_STORE_MULTI);
  assign is_load = (cmd_op == `OP_LOAD_SINGLE) || (cmd_op == `OP_LOAD_MULTI);

  assign reg_span = {1'b0, cmd_reg} + {1'b0, cnt_nxt};
  assign bad_count = (cnt_nxt == 4'h0) || (cnt_nxt > `MAX_REGS) || (reg_span > `NUM_REGS);

  always @* begin
    cnt_nxt = ((cmd_op == `OP_STORE_SINGLE) || (cmd_op == `OP_LOAD_SINGLE)) ? 4'h1 : cmd_count;
    start_nxt = cmd_indirect ? acc_r[15:0] : cmd_addr;
  end

  // geometry property select; row stride is header, guard and two words per column
  always @* begin
    case (cmd_prop)
      `PROP_START: prop_nxt = {16'h0000, cmd_addr};
      `PROP_COLS: prop_nxt = {28'h0000000, arr_cols};
      `PROP_ROWS: prop_nxt = {16'h0000, arr_rows};
      `PROP_END: prop_nxt = {16'h0000, cmd_addr} + arr_rows * ({27'h0000000, arr_cols, 1'b0} + 32'h00000002) - 32'h00000001;
      `PROP_INC: prop_nxt = {27'h0000000, arr_cols, 1'b0} + 32'h00000002;
      default: prop_nxt = acc_r;
    endcase
  end

  // guard first, registers in order, low half then high half
  always @* begin
    pw = push_r - 5'h01;
    pidx = base_r + pw[4:1];
    if (push_r == 5'h00) begin
      push_word = `GUARD_WORD;
    end else if (!pw[0]) begin
      push_word = regs[pidx][15:0];
    end else begin
      push_word = regs[pidx][31:16];
    end
  end

  assign cmd_ready = (state_r == ST_IDLE);
  assign busy = (state_r != ST_IDLE);
  assign fifo_in_valid = (state_r == ST_SFILL) && (push_r < wlen_r);
  // Memory ack drains the FIFO, so a slow memory stalls word production
  assign fifo_out_ready = (state_r == ST_SFILL) && mem_ack;
  assign mem_req = ((state_r == ST_SFILL) && fifo_out_valid) || (state_r == ST_SHDR) ||
                   (state_r == ST_LHDR) || (state_r == ST_LDATA);
  assign mem_we = (state_r == ST_SFILL) || (state_r == ST_SHDR);
  // header at record start, length low byte and checksum high byte
  assign mem_wdata = (state_r == ST_SHDR) ? {csum_r, 3'b000, wlen_r} : fifo_out_data;
  assign commit_ok = (csum_r == hsum_r);

  word_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // Data registers and load staging carry no reset, only control state does
  always @(posedge clk) begin
    if (ce) begin
      if ((state_r == ST_LDATA) && mem_ack) begin
        stage[pop_r] <= mem_rdata;
      end
      // staged words reach the registers only when checksum matches
      if ((state_r == ST_COMMIT) && commit_ok) begin
        for (i = 0; i < 16; i = i + 1) begin
          if ((i >= base_r) && (i < base_r + wlen_r[4:1])) begin
            regs[i] <= {stage[2 * (i - base_r) + 2], stage[2 * (i - base_r) + 1]};
          end
        end
      end else if (reg_wr_en) begin
        regs[reg_wr_idx] <= reg_wr_data;
      end
      reg_rd_data <= regs[reg_rd_idx];
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      start_r <= 16'h0000;
      base_r <= 4'h0;
      wlen_r <= 5'h00;
      push_r <= 5'h00;
      pop_r <= 5'h00;
      csum_r <= `CSUM_RESET;
      hsum_r <= `CSUM_RESET;
      mem_addr_r <= 16'h0000;
      acc_r <= `ACC_RESET;
      done_r <= 1'b0;
      err_len_r <= 1'b0;
      err_sum_r <= 1'b0;
      err_cmd_r <= 1'b0;
    end else if (ce) begin
      done_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (cmd_valid) begin
            err_len_r <= 1'b0;
            err_sum_r <= 1'b0;
            err_cmd_r <= 1'b0;
            start_r <= start_nxt;
            base_r <= cmd_reg;
            // length is data words plus one
            wlen_r <= {cnt_nxt, 1'b1};
            push_r <= 5'h00;
            pop_r <= 5'h00;
            csum_r <= `CSUM_RESET;
            if (cmd_op == `OP_WRITE_PROP) begin
              acc_r <= prop_nxt;
              done_r <= 1'b1;
            end else if ((!is_store && !is_load) || bad_count) begin
              err_cmd_r <= 1'b1;
              done_r <= 1'b1;
            end else if (is_store) begin
              mem_addr_r <= start_nxt + 16'h0001;
              state_r <= ST_SFILL;
            end else begin
              mem_addr_r <= start_nxt;
              state_r <= ST_LHDR;
            end
          end
        end
        ST_SFILL: begin
          if (fifo_in_valid && fifo_in_ready) begin
            push_r <= push_r + 5'h01;
            csum_r <= csum_add(csum_r, push_word);
          end
          if (mem_ack && fifo_out_valid) begin
            pop_r <= pop_r + 5'h01;
            mem_addr_r <= mem_addr_r + 16'h0001;
            // Header goes last so its checksum covers every data word
            if (pop_r == wlen_r - 5'h01) begin
              mem_addr_r <= start_r;
              state_r <= ST_SHDR;
            end
          end
        end
        ST_SHDR: begin
          if (mem_ack) begin
            done_r <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        ST_LHDR: begin
          if (mem_ack) begin
            hsum_r <= mem_rdata[15:8];
            // header length must match the requested count
            if (mem_rdata[7:0] != {3'b000, wlen_r}) begin
              err_len_r <= 1'b1;
              done_r <= 1'b1;
              state_r <= ST_IDLE;
            end else begin
              mem_addr_r <= mem_addr_r + 16'h0001;
              state_r <= ST_LDATA;
            end
          end
        end
        ST_LDATA: begin
          if (mem_ack) begin
            // checksum accumulated over guard and data
            csum_r <= csum_add(csum_r, mem_rdata);
            pop_r <= pop_r + 5'h01;
            mem_addr_r <= mem_addr_r + 16'h0001;
            if (pop_r == wlen_r - 5'h01) begin
              state_r <= ST_COMMIT;
            end
          end
        end
        ST_COMMIT: begin
          // mismatch flags a checksum error, nothing loaded
          if (!commit_ok) begin
            err_sum_r <= 1'b1;
          end
          done_r <= 1'b1;
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// >>> nv_record_props.sv
// Port checker for the record engine
`timescale 1ns/100ps
module nv_record_props (
  input wire clk,
  input wire resetn,
  input wire ce,
  input wire cmd_valid,
  input wire cmd_ready,
  input wire [2:0] cmd_op,
  input wire cmd_indirect,
  input wire [15:0] cmd_addr,
  input wire [3:0] cmd_count,
  input wire [2:0] cmd_prop,
  input wire [3:0] arr_cols,
  input wire [31:0] acc_r,
  input wire busy,
  input wire done_r,
  input wire err_len_r,
  input wire err_cmd_r,
  input wire mem_req,
  input wire mem_we,
  input wire [15:0] mem_addr_r,
  input wire [15:0] mem_wdata,
  input wire mem_ack
);
  wire take = ce & cmd_valid & cmd_ready;
  reg [15:0] st_r;
  reg [3:0] n_r;
  reg ld_r;
  // Record start and size latched at take, so checks follow indirect starts too
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= 16'h0000;
      n_r <= 4'h0;
      ld_r <= 1'b0;
    end else if (take) begin
      st_r <= cmd_indirect ? acc_r[15:0] : cmd_addr;
      n_r <= cmd_op[0] ? cmd_count : 4'h1;
      ld_r <= cmd_op[1];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_store_start: assert property (take && cmd_op == 3'h0 ##1 ce |=> mem_req && mem_we && mem_addr_r == st_r + 16'h0001)
    else $error("single store did not start at guard word");
  a_guard_zero: assert property (mem_req && mem_we && mem_addr_r == st_r + 16'h0001 |-> mem_wdata == 16'h0000)
    else $error("guard word not zero");
  a_header_len: assert property (mem_req && mem_we && mem_addr_r == st_r |-> mem_wdata[7:0] == {3'h0, n_r, 1'b1})
    else $error("header length wrong");
  a_addr_span: assert property (mem_req |-> mem_addr_r - st_r <= {11'h000, n_r, 1'b1})
    else $error("access outside record");
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr_r) && $stable(mem_we))
    else $error("memory request dropped");
  a_load_reads: assert property (mem_req && ld_r |-> !mem_we)
    else $error("load wrote memory");
  a_done_once: assert property (done_r && ce && !take |=> !done_r)
    else $error("done longer than one cycle");
  a_inc_value: assert property (take && cmd_op == 3'h4 && cmd_prop == 3'h4 |=> acc_r == {27'h0, $past(arr_cols), 1'b0} + 32'h2)
    else $error("increment wrong");
  a_bad_count: assert property (take && cmd_op == 3'h1 && cmd_count > 4'hA |=> err_cmd_r && done_r && !mem_req)
    else $error("oversize record accepted");
  a_len_stop: assert property ($rose(err_len_r) |-> done_r && !mem_req)
    else $error("length error did not stop");
  cover property (take && cmd_op == 3'h1);
  cover property ($rose(err_len_r));
  cover property (take && cmd_op == 3'h4);
  cover property (take && cmd_op == 3'h3 && cmd_indirect);
endmodule
bind nv_record_engine nv_record_props u_props (.clk(clk), .resetn(resetn), .ce(ce), .cmd_valid(cmd_valid),
  .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_indirect(cmd_indirect), .cmd_addr(cmd_addr), .cmd_count(cmd_count),
  .cmd_prop(cmd_prop), .arr_cols(arr_cols), .acc_r(acc_r), .busy(busy), .done_r(done_r), .err_len_r(err_len_r),
  .err_cmd_r(err_cmd_r), .mem_req(mem_req), .mem_we(mem_we), .mem_addr_r(mem_addr_r), .mem_wdata(mem_wdata),
  .mem_ack(mem_ack));

// >>> nv_mem_model.sv
// Behavioural non-volatile word memory
`timescale 1ns/100ps
module nv_mem_model (
  input wire clk,
  input wire [1:0] dly,
  input wire req,
  input wire we,
  input wire [15:0] addr,
  input wire [15:0] wdata,
  output reg ack,
  output reg [15:0] rdata
);
  reg [15:0] m [0:255];
  reg [1:0] w;
  integer i;
  // Erased cells hold a pattern no valid header has
  initial begin
    for (i = 0; i < 256; i = i + 1) m[i] = 16'h5AA5;
    ack = 1'b0;
    rdata = 16'h0000;
    w = 2'h0;
  end
  always @(posedge clk) begin
    ack <= 1'b0;
    // Bus toggles when no answer stands, so stale data never matches
    rdata <= ~rdata;
    w <= 2'h0;
    if (req && !ack) begin
      if (w == dly) begin
        ack <= 1'b1;
        if (we) m[addr[7:0]] <= wdata;
        else rdata <= m[addr[7:0]];
      end else w <= w + 2'h1;
    end
  end
endmodule

// >>> testbench.sv
// Self-checking bench for the record engine
`timescale 1ns/100ps
module testbench;
  reg clk, resetn, ce, cmd_valid, cmd_indirect, reg_wr_en;
  reg [2:0] cmd_op, cmd_prop;
  reg [15:0] cmd_addr, arr_rows;
  reg [3:0] cmd_reg, cmd_count, arr_cols, reg_wr_idx, reg_rd_idx;
  reg [31:0] reg_wr_data, v;
  reg [1:0] dly;
  wire cmd_ready, busy, done_r, err_len_r, err_sum_r, err_cmd_r, mem_req, mem_we, mem_ack;
  wire [31:0] reg_rd_data, acc_r;
  wire [15:0] mem_addr_r, mem_wdata, mem_rdata;
  integer n_errors = 0, cmp_count = 0, i, k;
  reg [27:0] rows [0:7];
  reg [31:0] pexp [0:4];
  nv_record_engine dut (.clk(clk), .resetn(resetn), .ce(ce), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_indirect(cmd_indirect), .cmd_addr(cmd_addr), .cmd_reg(cmd_reg), .cmd_count(cmd_count),
    .cmd_prop(cmd_prop), .arr_cols(arr_cols), .arr_rows(arr_rows), .reg_wr_en(reg_wr_en), .reg_wr_idx(reg_wr_idx),
    .reg_wr_data(reg_wr_data), .reg_rd_idx(reg_rd_idx), .reg_rd_data(reg_rd_data), .acc_r(acc_r), .busy(busy),
    .done_r(done_r), .err_len_r(err_len_r), .err_sum_r(err_sum_r), .err_cmd_r(err_cmd_r), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr_r(mem_addr_r), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  nv_mem_model u_mem (.clk(clk), .dly(dly), .req(mem_req), .we(mem_we), .addr(mem_addr_r),
    .wdata(mem_wdata), .ack(mem_ack), .rdata(mem_rdata));
  function [31:0] dv(input [3:0] r);
    dv = 32'h9E3779B9 * ({28'h0000000, r} + 32'h00000001);
  endfunction
  function [7:0] cs(input [3:0] r, input [3:0] n);
    integer j;
    reg [31:0] x;
    begin
      cs = 8'h00;
      for (j = 0; j < n; j = j + 1) begin
        x = dv(r + j[3:0]);
        cs = cs + x[7:0] + x[15:8] + x[23:16] + x[31:24];
      end
    end
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cmd(input [2:0] op, input ind, input [15:0] a, input [3:0] r, input [3:0] n, input [2:0] p);
    begin
      @(posedge clk);
      cmd_op <= op;
      cmd_indirect <= ind;
      cmd_addr <= a;
      cmd_reg <= r;
      cmd_count <= n;
      cmd_prop <= p;
      cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
      for (k = 0; k < 200 && done_r !== 1'b1; k = k + 1) @(negedge clk);
      if (k == 200) n_errors = n_errors + 1;
    end
  endtask
  task wr(input [3:0] r, input [31:0] d);
    begin
      @(posedge clk);
      reg_wr_en <= 1'b1;
      reg_wr_idx <= r;
      reg_wr_data <= d;
      @(posedge clk);
      reg_wr_en <= 1'b0;
    end
  endtask
  task chkreg(input [3:0] r, input [31:0] d);
    begin
      @(posedge clk);
      reg_rd_idx <= r;
      @(posedge clk);
      @(negedge clk);
      chk(reg_rd_data, d);
    end
  endtask
  task tally_and_finish;
    begin
      if (n_errors == 0 && cmp_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors = n_errors + 1;
    tally_and_finish;
  end
  initial begin
    {resetn, cmd_valid, cmd_indirect, reg_wr_en, cmd_op, cmd_prop, cmd_addr} = 0;
    {cmd_reg, cmd_count, reg_wr_idx, reg_rd_idx, reg_wr_data, dly} = 0;
    ce = 1'b1;
    arr_cols = 4'h3;
    arr_rows = 16'h0002;
    rows[0] = {3'h0, 16'h0010, 4'h3, 4'h1, 1'b0};
    rows[1] = {3'h1, 16'h0020, 4'h0, 4'hA, 1'b0};
    rows[2] = {3'h1, 16'h0040, 4'h0, 4'h0, 1'b1};
    rows[3] = {3'h1, 16'h0040, 4'h0, 4'hB, 1'b1};
    rows[4] = {3'h1, 16'h0040, 4'hC, 4'h5, 1'b1};
    rows[5] = {3'h5, 16'h0040, 4'h0, 4'h1, 1'b1};
    rows[6] = {3'h7, 16'h0040, 4'h0, 4'h1, 1'b1};
    rows[7] = {3'h1, 16'h0060, 4'h6, 4'h2, 1'b0};
    pexp[0] = 32'h40;
    pexp[1] = 32'h3;
    pexp[2] = 32'h2;
    pexp[3] = 32'h4F;
    pexp[4] = 32'h8;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    for (i = 0; i < 16; i = i + 1) wr(i[3:0], dv(i[3:0]));
    for (i = 0; i < 8; i = i + 1) begin
      dly <= i[1:0];
      cmd(rows[i][27:25], 1'b0, rows[i][24:9], rows[i][8:5], rows[i][4:1], 3'h0);
      chk(err_cmd_r, {31'h0, rows[i][0]});
    end
    v = dv(4'h3);
    chk(u_mem.m[8'h10], {cs(4'h3, 4'h1), 8'h03});
    chk(u_mem.m[8'h11], 32'h0);
    chk(u_mem.m[8'h13], v[31:16]);
    chk(u_mem.m[8'h20], {cs(4'h0, 4'hA), 8'h15});
    v = dv(4'h7);
    chk(u_mem.m[8'h64], v[15:0]);
    cmd(3'h3, 1'b0, 16'h0020, 4'h6, 4'hA, 3'h0);
    chk(err_sum_r | err_len_r, 32'h0);
    for (i = 0; i < 10; i = i + 1) chkreg(i[3:0] + 4'h6, dv(i[3:0]));
    cmd(3'h3, 1'b0, 16'h0020, 4'h7, 4'h9, 3'h0);
    chk(err_len_r, 32'h1);
    chkreg(4'h7, dv(4'h1));
    // Damaged data word stands in for a corrupted record
    u_mem.m[8'h12] = ~u_mem.m[8'h12];
    cmd(3'h2, 1'b0, 16'h0010, 4'h1, 4'h1, 3'h0);
    chk(err_sum_r, 32'h1);
    chkreg(4'h1, dv(4'h1));
    // Repaired record must load again, so the error is not sticky
    u_mem.m[8'h12] = ~u_mem.m[8'h12];
    cmd(3'h2, 1'b0, 16'h0010, 4'h1, 4'h1, 3'h0);
    chk(err_sum_r, 32'h0);
    chkreg(4'h1, dv(4'h3));
    for (i = 0; i < 5; i = i + 1) begin
      cmd(3'h4, 1'b0, 16'h0040, 4'h0, 4'h0, i[2:0]);
      chk(acc_r, pexp[i]);
    end
    cmd(3'h4, 1'b0, 16'h0040 + 16'h0008, 4'h0, 4'h0, 3'h0);
    // Array rows hold arr_cols registers each
    cmd(3'h1, 1'b1, 16'h0000, 4'h2, 4'h3, 3'h0);
    chk(u_mem.m[8'h48], {cs(4'h2, 4'h3), 8'h07});
    cmd(3'h3, 1'b1, 16'h0000, 4'h0, 4'h3, 3'h0);
    chkreg(4'h0, dv(4'h2));
    chkreg(4'h2, dv(4'h4));
    @(posedge clk);
    resetn <= 1'b0;
    @(negedge clk);
    chk({cmd_ready, busy, mem_req, acc_r[28:0]}, {3'b100, 29'h0});
    @(posedge clk);
    resetn <= 1'b1;
    cmd(3'h4, 1'b0, 16'h0040, 4'h0, 4'h0, 3'h4);
    chk(acc_r, 32'h8);
    tally_and_finish;
  end
endmodule
